/* hdl/dlp_pkg.sv */
// constants for the dual log pot command controller
package dlp_pkg;
	// command byte decode, top two bits
	localparam logic [1:0] CMD_WIPER0 = 2'h0;
	localparam logic [1:0] CMD_WIPER1 = 2'h1;
	localparam logic [1:0] CMD_CONFIG = 2'h2;
	localparam logic [1:0] CMD_RSVD   = 2'h3;
	localparam int         SEL_HI     = 7;
	localparam int         SEL_LO     = 6;
	localparam int         POS_W      = 6;
	// configuration bit positions
	localparam int         CFG_OPT    = 0;
	localparam int         CFG_ZC     = 1;
	localparam int         CFG_STORE  = 2;
	localparam int         CFG_W      = 3;
	// volatile storage, gating on, option one
	localparam logic [2:0] CFG_RESET  = 3'h6;
	// fixed upper bits of the config read-back byte
	localparam logic [1:0] CFG_RD_TAG = 2'h2;
	localparam logic [2:0] CFG_RD_PAD = 3'h0;
	// mute positions of the two tapers
	localparam logic [5:0] MUTE_OPT1  = 6'h3F;
	localparam logic [5:0] MUTE_OPT2  = 6'h21;
	// timebase and gating window
	localparam int         CLK_NS     = 100;
	localparam int         TICK_US    = 1000;
	localparam int         TICK_CYC   = TICK_US * 1000 / CLK_NS;
	localparam int         WIN_MS     = 50;
	localparam int         WIN_TICKS  = WIN_MS * 1000 / TICK_US;
	localparam logic [5:0] WIN_LAST   = 6'(WIN_TICKS);
endpackage

/* hdl/dlp_cmd_ctrl.sv */
// command decode, wiper registers and zero-crossing gating
`timescale 1ns/1ps
// Function
// - one taper option shared by both channels
// - option one: 64 positions, 63 is mute
// - reset selects option one
// - option two: 34 positions, 33 is mute
// - gating opens 50ms window after command
// - watch each channel's terminals for zero
// - gated channel moves at its own crossing
// - window expiry applies pending position anyway
// - gating off applies position at once
// - top bits 00/01 select wiper 0/1
// - top bits 10 write configuration
// - top bits 11 reserved, no action
// - low six bits become wiper position
// - wiper bits 5..0 hold tap position
// - low three bits set configuration
// - config bit 1 enables gating
// - config bit 0 selects taper option
// - bit 2 set: volatile, mute at power-up
// - stop starts nonvolatile commit
module dlp_cmd_ctrl #(
	parameter int TICK_CYC = dlp_pkg::TICK_CYC
) (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       rst_n,
	// from the serial front end, same clock
	input  wire logic       cmd_valid,
	input  wire logic [7:0] cmd_byte,
	input  wire logic       stop_seen,
	// analog comparators, high equals low terminal
	input  wire logic [1:0] zc_equal,
	// applied tap positions to the ladders
	output logic      [5:0] tap0_pos,
	output logic      [5:0] tap1_pos,
	// read-back bytes for the front end
	output logic      [7:0] wiper0_rd,
	output logic      [7:0] wiper1_rd,
	output logic      [7:0] config_rd,
	// nonvolatile commit request
	output logic            nv_commit
);
	localparam logic [13:0] TICK_LAST = 14'(TICK_CYC - 1);

	function automatic logic [5:0] clamp_pos(input logic [5:0] pos,
	                                         input logic       opt2);
		logic [5:0] mute;
		mute = opt2 ? dlp_pkg::MUTE_OPT2 : dlp_pkg::MUTE_OPT1;
		clamp_pos = (pos > mute) ? mute : pos;
	endfunction

	logic [1:0]  zc_meta_q;
	logic [1:0]  zc_sync_q;
	logic [13:0] div_q,  div_d;
	logic        tick;
	logic [2:0]  cfg_q,  cfg_d;
	logic [5:0]  wip_q  [2];
	logic [5:0]  wip_d  [2];
	logic [5:0]  tap_q  [2];
	logic [5:0]  tap_d  [2];
	logic [5:0]  cnt_q  [2];
	logic [5:0]  cnt_d  [2];
	logic [1:0]  pend_q, pend_d;
	logic [5:0]  pos_q  [2];
	logic [5:0]  pos_d  [2];
	logic        cwait_q, cwait_d;
	logic        commit_q, commit_d;
	logic [1:0]  sel;
	logic        zc_en;

	assign sel   = cmd_byte[dlp_pkg::SEL_HI:dlp_pkg::SEL_LO];
	assign zc_en = cfg_q[dlp_pkg::CFG_ZC];
	assign tick  = (div_q == TICK_LAST);

	// comparator inputs are asynchronous
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			zc_meta_q <= 2'h0;
			zc_sync_q <= 2'h0;
		end else begin
			zc_meta_q <= zc_equal;
			zc_sync_q <= zc_meta_q;
		end
	end

	always_comb begin
		div_d    = tick ? 14'h0000 : div_q + 14'h0001;
		cfg_d    = cfg_q;
		cwait_d  = cwait_q;
		commit_d = 1'b0;
		pend_d   = pend_q;
		for (int c = 0; c < 2; c++) begin
			wip_d[c] = wip_q[c];
			tap_d[c] = tap_q[c];
			cnt_d[c] = cnt_q[c];
			// pending change: crossing or expiry applies it
			if (pend_q[c]) begin
				if (tick)
					cnt_d[c] = cnt_q[c] + 6'h01;
				if (!zc_en || zc_sync_q[c] ||
				    (tick && cnt_q[c] == dlp_pkg::WIN_LAST - 6'h01)) begin
					tap_d[c]  = wip_q[c];
					pend_d[c] = 1'b0;
				end
			end
		end
		if (cmd_valid) begin
			case (sel)
				dlp_pkg::CMD_WIPER0, dlp_pkg::CMD_WIPER1: begin
					for (int c = 0; c < 2; c++) begin
						if (sel[0] == c[0]) begin
							wip_d[c] = cmd_byte[5:0];
							cnt_d[c] = 6'h00;
							if (zc_en) begin
								pend_d[c] = 1'b1;
							end else begin
								tap_d[c]  = cmd_byte[5:0];
								pend_d[c] = 1'b0;
							end
						end
					end
				end
				dlp_pkg::CMD_CONFIG: begin
					cfg_d = cmd_byte[dlp_pkg::CFG_W-1:0];
				end
				dlp_pkg::CMD_RSVD: begin
					cfg_d = cfg_q;
				end
				default: begin
					cfg_d = cfg_q;
				end
			endcase
		end
		// nonvolatile commit waits for gating to finish
		if (stop_seen && !cfg_q[dlp_pkg::CFG_STORE])
			cwait_d = 1'b1;
		if (cwait_q && pend_q == 2'h0 && !stop_seen) begin
			cwait_d  = 1'b0;
			commit_d = 1'b1;
		end
		for (int c = 0; c < 2; c++)
			pos_d[c] = clamp_pos(tap_q[c],
			                     cfg_q[dlp_pkg::CFG_OPT]);
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			div_q    <= 14'h0000;
			cfg_q    <= dlp_pkg::CFG_RESET;
			pend_q   <= 2'h0;
			cwait_q  <= 1'b0;
			commit_q <= 1'b0;
			for (int c = 0; c < 2; c++) begin
				wip_q[c] <= dlp_pkg::MUTE_OPT1;
				tap_q[c] <= dlp_pkg::MUTE_OPT1;
				cnt_q[c] <= 6'h00;
				pos_q[c] <= dlp_pkg::MUTE_OPT1;
			end
		end else begin
			div_q    <= div_d;
			cfg_q    <= cfg_d;
			pend_q   <= pend_d;
			cwait_q  <= cwait_d;
			commit_q <= commit_d;
			wip_q    <= wip_d;
			tap_q    <= tap_d;
			cnt_q    <= cnt_d;
			pos_q    <= pos_d;
		end
	end

	assign tap0_pos  = pos_q[0];
	assign tap1_pos  = pos_q[1];
	assign wiper0_rd = {dlp_pkg::CMD_WIPER0, wip_q[0]};
	assign wiper1_rd = {dlp_pkg::CMD_WIPER1, wip_q[1]};
	assign config_rd = {dlp_pkg::CFG_RD_TAG, dlp_pkg::CFG_RD_PAD, cfg_q};
	assign nv_commit = commit_q;

	default clocking dc @(posedge mclk); endclocking
	default disable iff (!rst_n);

	opt_shared_a: assert property (
		cfg_q[0] |=> tap0_pos <= 6'h21 && tap1_pos <= 6'h21)
		else $error("tap beyond option two mute");
	mute_one_a: assert property (
		!cfg_q[0] && tap_q[0] == 6'h3F && $stable(cfg_q) |=> tap0_pos == 6'h3F)
		else $error("option one mute not applied");
	gate_hold_a: assert property (
		cmd_valid && sel == 2'h0 && zc_en
		|=> pend_q[0] && wip_q[0] == $past(cmd_byte[5:0]) && cnt_q[0] == 6'h00)
		else $error("gated command not held pending");
	zc_apply_a: assert property (
		pend_q[0] && zc_sync_q[0] && !(cmd_valid && sel == 2'h0)
		|=> !pend_q[0] && tap_q[0] == $past(wip_q[0]))
		else $error("crossing did not apply wiper");
	win_bound_a: assert property (
		pend_q[0] |-> cnt_q[0] < 6'd50)
		else $error("gating window overran");
	no_gate_a: assert property (
		cmd_valid && sel == 2'h1 && !zc_en
		|=> tap_q[1] == $past(cmd_byte[5:0]) && !pend_q[1]
		##1 tap1_pos == (($past(cfg_q[0]) && $past(cmd_byte[5:0], 2) > 6'h21)
		                 ? 6'h21 : $past(cmd_byte[5:0], 2)))
		else $error("ungated wiper not applied at once");
	cfg_write_a: assert property (
		cmd_valid && sel == 2'h2 |=> cfg_q == $past(cmd_byte[2:0]))
		else $error("config write lost");
	rsvd_cmd_a: assert property (
		cmd_valid && sel == 2'h3 && pend_q == 2'h0
		|=> $stable(cfg_q) && $stable(wiper0_rd) && $stable(wiper1_rd))
		else $error("reserved command changed state");
	nv_commit_a: assert property (
		nv_commit |-> $past(cwait_q) && $past(pend_q) == 2'h0)
		else $error("commit without pending stop");

	gated_cv: cover property (pend_q[0] && zc_sync_q[0]);
	timeout_cv: cover property (pend_q[1] ##1 !pend_q[1] && !zc_sync_q[1]);
	commit_cv: cover property (stop_seen ##[1:20] nv_commit);
endmodule

/* tb/dlp_master_model.sv */
// bus master proxy issuing command bytes and stop markers
`timescale 1ns/1ps
module dlp_master_model (
	// clock
	input  wire logic       mclk,
	// command side
	output logic            cmd_valid,
	output logic      [7:0] cmd_byte,
	output logic            stop_seen
);
	initial begin
		cmd_valid = 1'b0;
		cmd_byte  = 8'h00;
		stop_seen = 1'b0;
	end
	// one byte per command, strobe lasts one cycle
	task automatic send(input logic [7:0] b);
		@(posedge mclk);
		cmd_valid <= 1'b1;
		cmd_byte  <= b;
		@(posedge mclk);
		cmd_valid <= 1'b0;
		cmd_byte  <= ~b;
	endtask
	// stop closes a write; starts the commit when nonvolatile
	task automatic stop();
		@(posedge mclk);
		stop_seen <= 1'b1;
		@(posedge mclk);
		stop_seen <= 1'b0;
	endtask
endmodule

/* tb/tb_top.sv */
// self-checking bench for the command controller
`timescale 1ns/1ps
module tb_top;
	logic       mclk = 1'b0;
	logic       rst_n = 1'b0;
	logic [1:0] zc_equal = 2'h0;
	logic       cmd_valid, stop_seen, nv_commit;
	logic [7:0] cmd_byte, wiper0_rd, wiper1_rd, config_rd;
	logic [5:0] tap0_pos, tap1_pos, q;
	int         miscompares = 0;
	int         comparisons = 0;
	int         n;
	always #50 mclk = ~mclk;
	dlp_master_model mst (.mclk, .cmd_valid, .cmd_byte, .stop_seen);
	dlp_cmd_ctrl #(.TICK_CYC(10)) dut (.mclk, .rst_n, .cmd_valid,
		.cmd_byte, .stop_seen, .zc_equal, .tap0_pos, .tap1_pos,
		.wiper0_rd, .wiper1_rd, .config_rd, .nv_commit);
	function automatic logic [5:0] clamp(input logic [5:0] v, input logic o2);
		return (o2 && v > 6'h21) ? 6'h21 : v;
	endfunction
	task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", w, e, g);
		end
	endtask
	task automatic wt(input int c);
		repeat (c) @(posedge mclk);
		#1;
	endtask
	task automatic wr(input logic ch, input logic [5:0] v, input logic o2);
		mst.send({1'b0, ch, v});
		wt(4);
		chk("wiper_rd", {1'b0, ch, v}, ch ? wiper1_rd : wiper0_rd);
		q = ch ? tap1_pos : tap0_pos;
		chk("tap_pos", {2'h0, clamp(v, o2)}, {2'h0, q});
	endtask
	task automatic cfg(input logic [7:0] b, input logic [7:0] e);
		mst.send(b);
		wt(3);
		chk("config_rd", e, config_rd);
	endtask
	task automatic watch(output int c);
		c = 0;
		repeat (8) begin
			wt(1);
			if (nv_commit === 1'b1)
				c++;
		end
	endtask
	task automatic stops(output int c);
		mst.stop();
		watch(c);
	endtask
	task automatic conclude();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (4000) @(posedge mclk);
		miscompares++;
		conclude();
	end
	initial begin
		void'($urandom(32'hD0B9));
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		wt(1);
		chk("config_rd", 8'h86, config_rd);
		chk("wiper0_rd", 8'h3F, wiper0_rd);
		chk("wiper1_rd", 8'h7F, wiper1_rd);
		chk("tap0_pos", 8'h3F, {2'h0, tap0_pos});
		cfg(8'hB8, 8'h80);
		for (int i = 0; i < 8; i++)
			wr(1'($urandom), 6'($urandom), 1'b0);
		wr(1'b1, 6'h3F, 1'b0);
		wr(1'b0, 6'h11, 1'b0);
		mst.send(8'hC5);
		wt(4);
		chk("wiper0_rd", 8'h11, wiper0_rd);
		chk("wiper1_rd", 8'h7F, wiper1_rd);
		chk("config_rd", 8'h80, config_rd);
		cfg(8'h81, 8'h81);
		for (int i = 0; i < 4; i++)
			wr(1'($urandom), 6'($urandom), 1'b1);
		wr(1'b1, 6'h22, 1'b1);
		wr(1'b0, 6'h28, 1'b1);
		cfg(8'h82, 8'h82);
		chk("tap0_pos", 8'h28, {2'h0, tap0_pos});
		mst.send(8'h05);
		wt(10);
		chk("tap0_pos", 8'h28, {2'h0, tap0_pos});
		@(posedge mclk);
		zc_equal <= 2'h1;
		wt(6);
		chk("tap0_pos", 8'h05, {2'h0, tap0_pos});
		chk("tap1_pos", 8'h22, {2'h0, tap1_pos});
		@(posedge mclk);
		zc_equal <= 2'h0;
		mst.send(8'h47);
		wt(300);
		mst.send(8'h4A);
		wt(470);
		chk("tap1_pos", 8'h22, {2'h0, tap1_pos});
		wt(40);
		chk("tap1_pos", 8'h0A, {2'h0, tap1_pos});
		cfg(8'h80, 8'h80);
		stops(n);
		chk("nv_commit", 8'h01, 8'(n));
		cfg(8'h82, 8'h82);
		mst.send(8'h09);
		stops(n);
		chk("nv_commit", 8'h00, 8'(n));
		@(posedge mclk);
		zc_equal <= 2'h1;
		watch(n);
		chk("nv_commit", 8'h01, 8'(n));
		chk("tap0_pos", 8'h09, {2'h0, tap0_pos});
		@(posedge mclk);
		zc_equal <= 2'h0;
		cfg(8'h84, 8'h84);
		stops(n);
		chk("nv_commit", 8'h00, 8'(n));
		conclude();
	end
endmodule
